// file: logic/hdlm_top.sv
// APB bridge to the registers of the companion high-voltage die over a three-wire link
// Functional notes
// - Three wires: clock, two-way data, interrupt; this side is always master.
// - Link clock runs at the core clock divided by eight.
// - A finished read puts the returned byte in data register bits 7:0.
// - Command 0x00 reads remote config, 0x02 remote status, 0x08 writes remote config; other codes reserved.
// - Remote interrupt copies the remote status into the data register.
// - Writing the config mirror forwards the value to the remote config.
// - After forwarding, the config mirror takes the value read back.
// - Status mirror changes only on interrupt or keyhole status read.
// - Command bit 0 is high while a transfer runs; no new command then.
// - Command bit 1 shows received parity: one good, zero failed.
// - Command bit 2 shows the slave answer: one ack, zero nack.
// - Command bit 3 is high while a mirror write is being forwarded.
// - Command register reads only status flags; bits 31:4 read zero.
// - Data register holds last command in bits 11:8, shift byte in 7:0.
`timescale 1ns/1ps
`include "hdlm_params.svh"
module hdlm_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  output logic                   DIE_LINK_CLOCK,
  input  wire logic              DIE_LINK_DATA_I,
  output logic                   DIE_LINK_DATA_O,
  output logic                   DIE_LINK_DATA_OE,
  input  wire logic              DIE_LINK_INTERRUPT
);

  hdlm_pkg::hdlm_state_word_t s;
  hdlm_pkg::hdlm_state_word_t next_s;

  logic [1:0]  pin_sync;
  logic        din;
  logic        irq_in;
  logic        apb_setup;
  logic        apb_wr;
  logic        busy;
  logic        mirror_busy;
  logic [31:0] status_word;
  logic        frame_done;
  logic [9:0]  rx_word;
  logic        hit_cmd;
  logic        hit_data;
  logic        hit_cfg;
  logic        hit_sta;
  logic        cmd_valid;

  // Pin inputs pass two flops before any logic sees them
  hdlm_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk      (CLK),
    .rst      (SYS_RST),
    .async_in ({DIE_LINK_INTERRUPT, DIE_LINK_DATA_I}),
    .sync_out (pin_sync)
  );

  assign din    = pin_sync[0];
  assign irq_in = pin_sync[1];

  function automatic logic [12:0] build_frame(input logic [3:0] cmd, input logic [7:0] data);
    build_frame = {cmd, data, ^data};
  endfunction : build_frame

  assign apb_setup = PSEL && !PENABLE;
  assign apb_wr    = PSEL && PENABLE && PWRITE;
  assign hit_cmd   = PADDR == `HDLM_OFF_COMMAND;
  assign hit_data  = PADDR == `HDLM_OFF_DATA;
  assign hit_cfg   = PADDR == `HDLM_OFF_CFG_MIRROR;
  assign hit_sta   = PADDR == `HDLM_OFF_STA_MIRROR;
  assign cmd_valid = (PWDATA[31:4] == 28'h0000000) &&
                     ((PWDATA[3:0] == `HDLM_CMD_RD_CFG) || (PWDATA[3:0] == `HDLM_CMD_RD_STA) ||
                      (PWDATA[3:0] == `HDLM_CMD_WR_CFG));

  // Busy covers the running frame and anything queued behind it
  assign busy        = (s.state != hdlm_pkg::HDLM_ST_IDLE) || s.key_pend || s.mirror_pend || s.irq_pend;
  assign mirror_busy = s.mirror_pend ||
                       ((s.state != hdlm_pkg::HDLM_ST_IDLE) && (s.src == hdlm_pkg::HDLM_SRC_MIR));
  assign status_word = {28'h0000000, mirror_busy, s.ack, s.par_ok, busy};

  assign frame_done = (s.state == hdlm_pkg::HDLM_ST_RECV) && (s.phase == `HDLM_PHASE_LAST) &&
                      (s.bit_cnt == `HDLM_RX_LAST_BIT);
  assign rx_word    = {s.shift_rx[8:0], din};

  always_comb begin
    next_s          = s;
    next_s.irq_prev = irq_in;
    next_s.pslverr  = s.pslverr;

    // Frame engine
    unique case (s.state)
      hdlm_pkg::HDLM_ST_IDLE: begin
        if (s.key_pend) begin
          next_s.key_pend = 1'b0;
          next_s.src      = hdlm_pkg::HDLM_SRC_KEY;
          next_s.cur_cmd  = s.key_cmd;
          next_s.shift_tx = build_frame(s.key_cmd,
                                        (s.key_cmd == `HDLM_CMD_WR_CFG) ? s.data_byte : `HDLM_RST_BYTE);
        end else if (s.mirror_pend) begin
          next_s.mirror_pend = 1'b0;
          next_s.src         = hdlm_pkg::HDLM_SRC_MIR;
          next_s.cur_cmd     = `HDLM_CMD_WR_CFG;
          next_s.shift_tx    = build_frame(`HDLM_CMD_WR_CFG, s.cfg_mirror);
        end else if (s.irq_pend) begin
          next_s.irq_pend = 1'b0;
          next_s.src      = hdlm_pkg::HDLM_SRC_IRQ;
          next_s.cur_cmd  = `HDLM_CMD_RD_STA;
          next_s.shift_tx = build_frame(`HDLM_CMD_RD_STA, `HDLM_RST_BYTE);
        end
        if (s.key_pend || s.mirror_pend || s.irq_pend) begin
          next_s.state   = hdlm_pkg::HDLM_ST_SEND;
          next_s.phase   = 3'h0;
          next_s.bit_cnt = 5'h00;
          next_s.dout    = next_s.shift_tx[12];
          next_s.doe     = 1'b1;
        end
      end
      hdlm_pkg::HDLM_ST_SEND: begin
        next_s.phase = s.phase + 3'h1;
        if (s.phase == `HDLM_PHASE_LAST) begin
          if (s.bit_cnt == `HDLM_TX_LAST_BIT) begin
            next_s.state   = hdlm_pkg::HDLM_ST_TURN;
            next_s.doe     = 1'b0;
            next_s.dout    = 1'b0;
            next_s.bit_cnt = 5'h00;
          end else begin
            next_s.shift_tx = {s.shift_tx[11:0], 1'b0};
            next_s.dout     = s.shift_tx[11];
            next_s.bit_cnt  = s.bit_cnt + 5'h01;
          end
        end
      end
      hdlm_pkg::HDLM_ST_TURN: begin
        next_s.phase = s.phase + 3'h1;
        if (s.phase == `HDLM_PHASE_LAST) begin
          next_s.state = hdlm_pkg::HDLM_ST_RECV;
        end
      end
      hdlm_pkg::HDLM_ST_RECV: begin
        next_s.phase = s.phase + 3'h1;
        if (s.phase == `HDLM_PHASE_LAST) begin
          next_s.shift_rx = rx_word;
          next_s.bit_cnt  = s.bit_cnt + 5'h01;
        end
        if (frame_done) begin
          next_s.state  = hdlm_pkg::HDLM_ST_IDLE;
          next_s.ack    = rx_word[9];
          next_s.par_ok = (^rx_word[8:1]) == rx_word[0];
        end
      end
    endcase

    // Link clock high for four of every eight core cycles
    next_s.die_link_clock = (s.state != hdlm_pkg::HDLM_ST_IDLE) && (s.phase >= `HDLM_PHASE_RISE) &&
                  (s.phase != `HDLM_PHASE_LAST);

    // Software writes
    if (apb_wr && hit_data) begin
      next_s.data_byte = PWDATA[7:0];
    end
    if (apb_wr && hit_cmd) begin
      next_s.cmd_field = PWDATA[3:0];
      if (!busy && cmd_valid) begin
        next_s.key_pend = 1'b1;
        next_s.key_cmd  = PWDATA[3:0];
      end
    end

    // Read-back results; a fresh software write to the config mirror wins over the old readback
    if (frame_done) begin
      unique case (s.src)
        hdlm_pkg::HDLM_SRC_KEY: begin
          next_s.data_byte = rx_word[8:1];
          if (s.cur_cmd == `HDLM_CMD_RD_STA) begin
            next_s.sta_mirror = rx_word[8:1];
          end
        end
        hdlm_pkg::HDLM_SRC_MIR: begin
          next_s.cfg_mirror = rx_word[8:1];
        end
        hdlm_pkg::HDLM_SRC_IRQ: begin
          next_s.data_byte  = rx_word[8:1];
          next_s.sta_mirror = rx_word[8:1];
        end
        default: begin
          next_s.data_byte = s.data_byte;
        end
      endcase
    end
    if (apb_wr && hit_cfg) begin
      next_s.cfg_mirror  = PWDATA[7:0];
      next_s.mirror_pend = 1'b1;
    end

    // Interrupt edge queues a status read; a new edge beats the clear
    if (irq_in && !s.irq_prev) begin
      next_s.irq_pend = 1'b1;
    end

    // Read data and error are captured in the setup phase
    if (apb_setup) begin
      next_s.pslverr = !(hit_cmd || hit_data || hit_cfg || hit_sta);
      next_s.prdata  = `HDLM_RST_WORD;
      if (hit_cmd) begin
        next_s.prdata = status_word;
      end else if (hit_data) begin
        next_s.prdata = {20'h00000, s.cmd_field, s.data_byte};
      end else if (hit_cfg) begin
        next_s.prdata = {24'h000000, s.cfg_mirror};
      end else if (hit_sta) begin
        next_s.prdata = {24'h000000, s.sta_mirror};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign PRDATA           = s.prdata;
  assign PREADY           = 1'b1;
  assign PSLVERR          = s.pslverr;
  assign DIE_LINK_CLOCK   = s.die_link_clock;
  assign DIE_LINK_DATA_O  = s.dout;
  assign DIE_LINK_DATA_OE = s.doe;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence launch_s;
    (s.state == hdlm_pkg::HDLM_ST_IDLE) && s.key_pend;
  endsequence

  sequence send_s;
    (s.state == hdlm_pkg::HDLM_ST_SEND) && s.doe;
  endsequence

  die_link_clock_high_four_a: assert property ($rose(s.die_link_clock) |-> s.die_link_clock[*4] ##1 !s.die_link_clock)
    else $error("Link clock high time is not four cycles");

  die_link_clock_period_a: assert property (($rose(s.die_link_clock) &&
                                   !((s.state == hdlm_pkg::HDLM_ST_RECV) && (s.bit_cnt == `HDLM_RX_LAST_BIT)))
                                  |-> ##8 $rose(s.die_link_clock))
    else $error("Link clock period is not eight cycles");

  key_write_start_a: assert property ((apb_wr && hit_cmd && !busy && PWDATA == 32'h00000008)
                                      |=> launch_s ##1 (send_s and s.shift_tx[12:9] == 4'h8))
    else $error("Keyhole write did not start a frame");

  bad_cmd_ignored_a: assert property ((apb_wr && hit_cmd && !busy && !cmd_valid) |=> !s.key_pend)
    else $error("Reserved command started a transfer");

  read_data_back_a: assert property ((frame_done && s.src != hdlm_pkg::HDLM_SRC_MIR)
                                     |=> s.data_byte == $past(rx_word[8:1]))
    else $error("Read byte not placed in data register");

  irq_copy_a: assert property ((frame_done && s.src == hdlm_pkg::HDLM_SRC_IRQ)
                               |=> (s.sta_mirror == s.data_byte))
    else $error("Interrupt read did not copy status");

  irq_launch_a: assert property ((irq_in && !s.irq_prev)
                                 |-> ##[1:400] ((s.src == hdlm_pkg::HDLM_SRC_IRQ) && busy))
    else $error("Interrupt did not launch a status read");

  mirror_forward_a: assert property ((apb_wr && hit_cfg) |=> mirror_busy ##1 status_word[3])
    else $error("Config mirror write not forwarded");

  cfg_readback_a: assert property ((frame_done && s.src == hdlm_pkg::HDLM_SRC_MIR && !(apb_wr && hit_cfg))
                                   |=> s.cfg_mirror == $past(rx_word[8:1]))
    else $error("Config mirror not updated from readback");

  sta_only_on_read_a: assert property ($changed(s.sta_mirror) |-> $past(frame_done) &&
                                       $past(s.cur_cmd) == `HDLM_CMD_RD_STA)
    else $error("Status mirror changed without a status read");

  busy_flag_a: assert property ((apb_setup && hit_cmd && (s.state != hdlm_pkg::HDLM_ST_IDLE))
                                |=> PRDATA[`HDLM_BIT_BUSY])
    else $error("Busy flag low during a transfer");

  parity_flag_a: assert property (frame_done |=> s.par_ok == ((^$past(rx_word[8:1])) == $past(rx_word[0])))
    else $error("Parity flag wrong");

  ack_flag_a: assert property (frame_done |=> s.ack == $past(rx_word[9]))
    else $error("Ack flag wrong");

  cmd_read_low_a: assert property ((apb_setup && hit_cmd) |=> s.prdata[31:4] == 28'h0000000)
    else $error("Command register upper bits not zero");

  cmd_field_a: assert property ((apb_wr && hit_cmd) |=> s.cmd_field == $past(PWDATA[3:0]))
    else $error("Data register command field not updated");

  sequence frame_open_s;
    $rose(s.doe);
  endsequence

  data_drive_a: assert property (DIE_LINK_DATA_OE == (s.state == hdlm_pkg::HDLM_ST_SEND))
    else $error("Data pin driven outside the send phase");

  clock_idle_a: assert property ((s.state == hdlm_pkg::HDLM_ST_IDLE) |-> !DIE_LINK_CLOCK)
    else $error("Link clock active between frames");

  read_zero_data_a: assert property (((s.state == hdlm_pkg::HDLM_ST_IDLE) && s.key_pend &&
                                      (s.key_cmd != `HDLM_CMD_WR_CFG)) |=> (s.shift_tx[8:1] == 8'h00))
    else $error("Read frame carries data");

  mirror_data_a: assert property (((s.state == hdlm_pkg::HDLM_ST_IDLE) && !s.key_pend && s.mirror_pend)
                                  |=> (s.shift_tx[8:1] == $past(s.cfg_mirror)))
    else $error("Forwarded byte differs from config mirror");

  sta_keyhole_a: assert property ((frame_done && (s.src == hdlm_pkg::HDLM_SRC_KEY) &&
                                   (s.cur_cmd == `HDLM_CMD_RD_STA)) |=> s.sta_mirror == $past(rx_word[8:1]))
    else $error("Keyhole status read did not refresh mirror");

  busy_refused_a: assert property ((apb_wr && hit_cmd && busy) |=> !s.key_pend)
    else $error("Command accepted while busy");

  mirror_flag_read_a: assert property ((apb_setup && hit_cmd && mirror_busy)
                                       |=> PRDATA[`HDLM_BIT_MIRROR_PND])
    else $error("Mirror busy flag not reported");

  turn_start_a: assert property (frame_open_s |-> ##104 ((s.state == hdlm_pkg::HDLM_ST_TURN) && !s.doe))
    else $error("Turnaround not after thirteen bits");

  frame_len_a: assert property (frame_open_s |-> ##191 frame_done)
    else $error("Frame is not twenty-four bit periods long");

endmodule : hdlm_top

// file: logic/hdlm_params.svh
// Register offsets, field positions, command codes and link timing of the die link master
`ifndef HDLM_PARAMS_SVH
`define HDLM_PARAMS_SVH

`define HDLM_OFF_COMMAND    12'h004
`define HDLM_OFF_DATA       12'h00c
`define HDLM_OFF_CFG_MIRROR 12'h010
`define HDLM_OFF_STA_MIRROR 12'h018

`define HDLM_RST_WORD       32'h00000000
`define HDLM_RST_BYTE       8'h00

`define HDLM_BIT_BUSY       0
`define HDLM_BIT_PARITY_OK  1
`define HDLM_BIT_ACK        2
`define HDLM_BIT_MIRROR_PND 3

`define HDLM_CMD_RD_CFG     4'h0
`define HDLM_CMD_RD_STA     4'h2
`define HDLM_CMD_WR_CFG     4'h8

`define HDLM_CLK_DIV        8
`define HDLM_PHASE_RISE     3'h3
`define HDLM_PHASE_LAST     3'h7
`define HDLM_TX_LAST_BIT    5'h0c
`define HDLM_RX_LAST_BIT    5'h09

`endif

// file: logic/hdlm_pkg.sv
// Types shared by the die link master
package hdlm_pkg;

  typedef enum logic [1:0] {
    HDLM_ST_IDLE,
    HDLM_ST_SEND,
    HDLM_ST_TURN,
    HDLM_ST_RECV
  } hdlm_state_t;

  typedef enum logic [1:0] {
    HDLM_SRC_KEY,
    HDLM_SRC_MIR,
    HDLM_SRC_IRQ
  } hdlm_src_t;

  typedef struct packed {
    hdlm_state_t  state;
    hdlm_src_t    src;
    logic [2:0]   phase;
    logic [4:0]   bit_cnt;
    logic [12:0]  shift_tx;
    logic [9:0]   shift_rx;
    logic [3:0]   cur_cmd;
    logic [3:0]   cmd_field;
    logic [7:0]   data_byte;
    logic [7:0]   cfg_mirror;
    logic [7:0]   sta_mirror;
    logic         ack;
    logic         par_ok;
    logic         key_pend;
    logic [3:0]   key_cmd;
    logic         mirror_pend;
    logic         irq_pend;
    logic         irq_prev;
    logic         die_link_clock;
    logic         dout;
    logic         doe;
    logic [31:0]  prdata;
    logic         pslverr;
  } hdlm_state_word_t;

endpackage : hdlm_pkg

// file: logic/hdlm_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module hdlm_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } hdlm_sync_t;

  hdlm_sync_t s;
  hdlm_sync_t next_s;

  always_comb begin
    next_s        = s;
    next_s.stage1 = async_in;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.stage2;

endmodule : hdlm_sync

// file: bench/hdlm_slave.sv
// Behavioural slave of the high-voltage end of the die link
`timescale 1ns/1ps
module hdlm_slave (
  input  wire logic       sclk,
  input  wire logic       sd,
  input  wire logic [7:0] sta,
  input  wire logic       nack,
  input  wire logic       bad_par,
  output logic            so,
  output logic            soe,
  output logic [7:0]      cfg
);
  logic [4:0]  n;
  logic [12:0] rx;
  logic [9:0]  tx;
  logic [7:0]  b;
  initial begin
    n = 5'h00;
    cfg = 8'h00;
    so = 1'b0;
    soe = 1'b0;
  end
  // Master bits sampled on the rising link clock
  always @(posedge sclk) begin
    n <= (n == 5'h17) ? 5'h00 : n + 5'h01;
    rx = {rx[11:0], sd};
    if (n == 5'h0c) begin
      if (rx[12:9] == 4'h8 && (^rx[8:1]) == rx[0]) cfg = rx[8:1] & 8'h1f;
      b = (rx[12:9] == 4'h2) ? sta : cfg;
      tx <= {~nack, b, (^b) ^ bad_par};
    end
  end
  // Reply bits change after the falling clock; a released line toggles
  always @(negedge sclk) begin
    if (n >= 5'h0e) begin
      soe <= 1'b1;
      so <= tx[5'h17 - n];
    end else begin
      soe <= 1'b0;
      so <= ~so;
    end
  end
endmodule : hdlm_slave

// file: bench/hv_die_link_master_bench.sv
// Self-checking bench of the die link master
`timescale 1ns/1ps
module hv_die_link_master_bench;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [11:0] pa;
  logic [31:0] pwd;
  logic [31:0] prd;
  logic        prdy;
  logic        perr;
  logic        lclk;
  logic        ldi;
  logic        ldo;
  logic        loe;
  logic        irq;
  logic [7:0]  sta;
  logic        nack;
  logic        badp;
  logic        so;
  logic        soe;
  logic [7:0]  rcfg;
  logic [31:0] r;
  logic        e;
  int          error_cnt;
  int          n_compared;
  int          rises;
  int          t;
  time         t0;
  assign ldi = loe ? ldo : (soe ? so : ~so);
  hdlm_top dut (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd),
    .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .DIE_LINK_CLOCK(lclk), .DIE_LINK_DATA_I(ldi),
    .DIE_LINK_DATA_O(ldo), .DIE_LINK_DATA_OE(loe), .DIE_LINK_INTERRUPT(irq));
  hdlm_slave part (.sclk(lclk), .sd(ldi), .sta(sta), .nack(nack), .bad_par(badp), .so(so), .soe(soe), .cfg(rcfg));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge lclk) rises <= rises + 1;
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (prdy !== 1'b1 && k < 100);
    if (prdy !== 1'b1) error_cnt++;
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, r, x);
    chk({nm, " error"}, {31'h0, e}, 32'h0);
  endtask : rd
  task automatic idle;
    int k;
    k = 0;
    r = 32'h1;
    while (r[0] !== 1'b0 && k < 400) begin
      apb(1'b0, 12'h004, 32'h0);
      k++;
    end
    if (r[0] !== 1'b0) error_cnt++;
  endtask : idle
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    #100000;
    error_cnt++;
    summarize;
  end
  initial begin
    {rst, psel, pen, pwr, pa, pwd, irq, nack, badp} = {1'b1, 50'h0};
    sta = 8'h3c;
    {error_cnt, n_compared} = {32'h0, 32'h0};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(12'h004, 32'h0, "cmd reset");
    rd(12'h00c, 32'h0, "data reset");
    rd(12'h010, 32'h0, "cfg mirror reset");
    rd(12'h018, 32'h0, "sta mirror reset");
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped error", {31'h0, e}, 32'h1);
    apb(1'b1, 12'h00c, 32'ha5);
    t = rises;
    apb(1'b1, 12'h004, 32'h8);
    rd(12'h004, 32'h1, "busy");
    @(posedge lclk);
    t0 = $time;
    @(posedge lclk);
    chk("link period", 32'(($time - t0) / 4), 32'd8);
    chk("data driven", {31'h0, loe}, 32'h1);
    idle;
    chk("link rises", 32'(rises - t), 32'd24);
    chk("clock idle", {31'h0, lclk}, 32'h0);
    chk("data released", {31'h0, loe}, 32'h0);
    chk("remote cfg", {24'h0, rcfg}, 32'h05);
    rd(12'h004, 32'h6, "flags");
    rd(12'h00c, 32'h805, "write readback");
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b1, 12'h00c, 32'h77);
    apb(1'b1, 12'h004, 32'h8);
    idle;
    chk("refused cmd", {24'h0, rcfg}, 32'h05);
    rd(12'h00c, 32'h83c, "sta read");
    rd(12'h018, 32'h3c, "sta mirror");
    apb(1'b1, 12'h004, 32'h0);
    idle;
    rd(12'h00c, 32'h005, "cfg read");
    sta <= 8'h81;
    apb(1'b1, 12'h010, 32'hff);
    rd(12'h004, 32'hf, "mirror busy");
    idle;
    chk("forwarded cfg", {24'h0, rcfg}, 32'h1f);
    rd(12'h010, 32'h1f, "cfg mirror");
    rd(12'h004, 32'h6, "mirror done");
    rd(12'h018, 32'h3c, "sta kept");
    irq <= 1'b1;
    repeat (8) @(posedge clk);
    idle;
    rd(12'h00c, 32'h081, "irq data");
    rd(12'h018, 32'h81, "irq mirror");
    irq <= 1'b0;
    nack <= 1'b1;
    badp <= 1'b1;
    apb(1'b1, 12'h004, 32'h0);
    idle;
    rd(12'h004, 32'h0, "nack flags");
    nack <= 1'b0;
    badp <= 1'b0;
    apb(1'b1, 12'h004, 32'h4);
    rd(12'h004, 32'h0, "reserved cmd");
    rd(12'h00c, 32'h41f, "last cmd");
    apb(1'b1, 12'h018, 32'h55);
    rd(12'h018, 32'h81, "sta read only");
    summarize;
  end
endmodule : hv_die_link_master_bench
